// File: hw/smcs_ctrl_status.sv
/*
 Control/status register logic of the serial master: register port, chip
 select drive, FIFO clear/push/pop strobes, DMA requests and interrupt.
 Assumes the FIFOs, shifter and divider live next to it on the same clock
 and report their fill levels and byte completions as synchronous signals.
*/
`timescale 1ns/1ps
module smcs_ctrl_status #(
   parameter int FIFO_DEPTH = 64,
   parameter int LVL_W      = $clog2(FIFO_DEPTH) + 1,
   parameter int RX_HIGH    = 48,
   parameter int TX_DREQ    = 32,
   parameter int RX_DREQ    = 32
) (
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic [smcs_pkg::ADDR_W-1:0] busAddr,
   input  wire logic [31:0]                busWdata,
   input  wire logic                       busWrite,
   input  wire logic                       busRead,
   output logic      [31:0]                busRdata,
   input  wire logic [LVL_W-1:0]           txLevel,
   input  wire logic [LVL_W-1:0]           rxLevel,
   input  wire logic [31:0]                rxHeadData,
   input  wire logic                       shifterIdle,
   input  wire logic                       byteDone,
   input  wire logic                       dmaFrameEnd,
   output logic                            txPush,
   output logic                            txPushWord,
   output logic      [31:0]                txData,
   output logic                            rxPop,
   output logic                            txClear,
   output logic                            rxClear,
   output logic                            serialHalt,
   output logic      [2:0]                 selectOut,
   output logic                            clockRestHigh,
   output logic                            clockPhase,
   output logic                            lowspeedProtocolSelect,
   output logic                            lineTurnToSlave,
   output logic      [15:0]                transferLength,
   output logic                            dmaTxReq,
   output logic                            dmaRxReq,
   output logic                            irq
);
   import smcs_pkg::*;

   logic [31:0] ctrlQ, ctrlD;
   logic [31:0] rdataQ, rdataD;
   logic [15:0] lengthQ;
   logic [15:0] byteCntQ;
   logic        releasedQ;
   logic        doneQ;
   logic        txPushQ, txWordQ, txClearQ, rxClearQ;
   logic [31:0] txDataQ;
   logic [2:0]  selectQ;

   // Address decode
   wire wrCtrl   = busWrite && (busAddr == OFF_CTRL);
   wire wrFifo   = busWrite && (busAddr == OFF_FIFO);
   wire rdCtrl   = busRead && (busAddr == OFF_CTRL);
   wire rdFifo   = busRead && (busAddr == OFF_FIFO);
   wire taQ      = ctrlQ[BIT_ACTIVE];
   wire wrLoad   = wrFifo && !taQ;
   wire wrTx     = wrFifo && taQ;

   // Named control fields
   wire       dmaEnable   = ctrlQ[BIT_DMA_REQUEST_ENABLE];
   wire       lsProtocol  = ctrlQ[BIT_LSPROT];
   wire       lsDmaEnable = ctrlQ[BIT_LSDMA];
   wire       longWord    = ctrlQ[BIT_LONGWORD];
   wire       autoRelease = ctrlQ[BIT_AUTOREL];
   wire [1:0] selField    = ctrlQ[BIT_SEL +: 2];
   // Lowspeed mode reaches DMA through its own enable bit
   wire       dmaOn = dmaEnable || (lsProtocol && lsDmaEnable);

   // FIFO state as seen by software
   wire rxEmpty   = (rxLevel == '0);
   wire rxFull    = (rxLevel == LVL_W'(FIFO_DEPTH));
   wire txFull    = (txLevel == LVL_W'(FIFO_DEPTH));
   // A push still in flight counts as one entry taken, so back-to-back byte writes
   // cannot overrun a FIFO whose level has not caught up yet
   wire txRoom    = (txLevel + LVL_W'(txPushQ)) < LVL_W'(FIFO_DEPTH);
   wire rxNeed    = taQ && (rxLevel >= LVL_W'(RX_HIGH));

   // Clear field source: control write or a control load through the FIFO
   wire [1:0] clrReq = wrCtrl ? busWdata[BIT_CLRTX +: 2] :
                       wrLoad ? busWdata[BIT_CLRTX +: 2] : 2'h0;

   // Next control word; frame end from DMA drops the active bit
   always_comb begin
      ctrlD = ctrlQ;
      if (wrCtrl) begin
         ctrlD = busWdata & CTRL_WMASK;
      end else if (wrLoad) begin
         ctrlD[7:0] = busWdata[7:0] & LOAD_WMASK;
      end
      if (dmaFrameEnd) begin
         ctrlD[BIT_ACTIVE] = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) ctrlQ <= CTRL_RESET;
      else        ctrlQ <= ctrlD;
   end

   // One-shot clears land in the cycle the new active bit appears;
   // serialHalt covers that cycle so no frame starts before the clear
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         txClearQ <= 1'b0;
         rxClearQ <= 1'b0;
      end else begin
         txClearQ <= clrReq[0];
         rxClearQ <= clrReq[1];
      end
   end

   // Transmit push: bytes normally, whole words for DMA or long lowspeed
   wire pushWord = dmaEnable || (lsProtocol && lsDmaEnable && longWord);
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         txPushQ <= 1'b0;
         txWordQ <= 1'b0;
         txDataQ <= 32'h0000_0000;
      end else begin
         txPushQ <= wrTx && txRoom;
         txWordQ <= pushWord;
         if (wrTx) txDataQ <= busWdata;
      end
   end

   // Transfer length is loaded by the first DMA word while inactive
   always_ff @(posedge clk) begin
      if (!rst_n)      lengthQ <= 16'h0000;
      else if (wrLoad) lengthQ <= busWdata[LEN_LSB +: 16];
   end

   // Byte count toward the programmed length, for automatic release
   wire [15:0] cntNext = byteCntQ + 16'h0001;
   wire        lastByte = byteDone && (cntNext == lengthQ) && (lengthQ != 0);
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         byteCntQ  <= 16'h0000;
         releasedQ <= 1'b0;
      end else if (!taQ || wrLoad) begin
         byteCntQ  <= 16'h0000;
         releasedQ <= 1'b0;
      end else begin
         if (byteDone) byteCntQ <= cntNext;
         releasedQ <= releasedQ || lastByte;
      end
   end

   // Done: active, shifter quiet, nothing queued and no write pending.
   // Register-sourced; a write in the same cycle clears it on the next edge.
   wire doneD = ctrlD[BIT_ACTIVE] && taQ && shifterIdle && (txLevel == '0)
                && !txPushQ && !wrTx;
   always_ff @(posedge clk) begin
      if (!rst_n) doneQ <= 1'b0;
      else        doneQ <= doneD;
   end

   // Chip select drive: per-line polarity, or the global one
   wire       selHeld = taQ && !(autoRelease && dmaOn && releasedQ);
   wire [2:0] polVec  = ctrlQ[BIT_SELPOL0 +: 3] | {3{ctrlQ[BIT_GPOL]}};
   logic [2:0] selectD;
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         // Reserved select code matches no line
         selectD[i] = (selHeld && (selField == 2'(i))) ? polVec[i]
                                                      : !polVec[i];
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) selectQ <= 3'h7;
      else        selectQ <= selectD;
   end

   // Status view of the control word
   wire [31:0] ctrlView = ctrlQ
                        | (32'(rxFull)   << BIT_RXFULL)
                        | (32'(rxNeed)   << BIT_RXNEED)
                        | (32'(!txFull)  << BIT_TXSPACE)
                        | (32'(!rxEmpty) << BIT_RXDATA)
                        | (32'(doneQ)    << BIT_DONE);

   // Read data valid only in the cycle after the strobe
   assign rdataD = rdCtrl ? ctrlView :
                   rdFifo ? rxHeadData : 32'h0000_0000;
   always_ff @(posedge clk) begin
      if (!rst_n) rdataQ <= 32'h0000_0000;
      else        rdataQ <= rdataD;
   end

   // Outputs
   assign busRdata               = rdataQ;
   assign rxPop                  = rdFifo && !rxEmpty;
   assign txPush                 = txPushQ;
   assign txPushWord             = txWordQ;
   assign txData                 = txDataQ;
   assign txClear                = txClearQ;
   assign rxClear                = rxClearQ;
   assign serialHalt             = rxFull || txClearQ || rxClearQ;
   assign selectOut              = selectQ;
   assign clockRestHigh          = ctrlQ[BIT_CLOCK_REST_POLARITY];
   assign clockPhase             = ctrlQ[BIT_CLOCK_PHASE];
   assign lowspeedProtocolSelect = lsProtocol;
   assign lineTurnToSlave        = ctrlQ[BIT_READEN];
   assign transferLength         = lengthQ;
   // DMA requests only while enabled; receive also drains a finished frame
   assign dmaTxReq = dmaOn && taQ && (txLevel <= LVL_W'(TX_DREQ));
   assign dmaRxReq = dmaOn && ((rxLevel > LVL_W'(RX_DREQ))
                     || (doneQ && !rxEmpty));
   // Level interrupt, held while the enabled condition lasts
   assign irq = (ctrlQ[BIT_RXIEN] && rxNeed)
             || (ctrlQ[BIT_DONEIEN] && doneQ);

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_frame_end_ta: assert property (dmaFrameEnd |=> !taQ)
      else $error("frame end did not clear active");
   a_idle_selects: assert property (
      !taQ |=> (selectOut == ~$past(polVec)))
      else $error("select asserted while inactive");
   a_idle_flags_read: assert property (
      rdCtrl && !taQ |=> !busRdata[BIT_RXNEED] && !busRdata[BIT_DONE])
      else $error("needs-reading or done read 1 while inactive");
   a_load_low_bits: assert property (
      wrLoad && !dmaFrameEnd |=>
      ctrlQ[7:0] == ($past(busWdata[7:0]) & LOAD_WMASK))
      else $error("FIFO write while inactive did not load control");
   a_txspace_full: assert property (
      rdCtrl && txFull |=> !busRdata[BIT_TXSPACE])
      else $error("transmit space shown while full");
   a_rxdata_flag: assert property (
      rdCtrl |=> busRdata[BIT_RXDATA] == ($past(rxLevel) != 0))
      else $error("receive data flag wrong");
   a_halt_on_full: assert property (rxFull |-> serialHalt)
      else $error("serial traffic not halted on full");
   a_done_cleared: assert property (wrTx |=> !doneQ ##1 !doneQ)
      else $error("done not cleared by transmit write");
   a_clear_oneshot: assert property (
      wrCtrl && busWdata[BIT_CLRTX] |=> txClear ##1 !txClear
      || $past(clrReq[0]))
      else $error("transmit clear not one cycle");
   a_no_dma_req: assert property (
      !dmaOn |-> !dmaTxReq && !dmaRxReq)
      else $error("DMA request while disabled");
   a_rx_irq: assert property (
      ctrlQ[BIT_RXIEN] && rxNeed |-> irq)
      else $error("receive interrupt missing");
   a_push_word: assert property (
      wrTx && txRoom && pushWord |=> txPush && txPushWord)
      else $error("word push not flagged");

   c_frame_end: cover property (taQ && dmaFrameEnd);
   c_auto_release: cover property (taQ && autoRelease && lastByte);
   c_long_push: cover property (txPush && txPushWord && lsProtocol);
   c_done_irq: cover property (doneQ && irq);

endmodule : smcs_ctrl_status

// File: shared/smcs_pkg.sv
/*
 Constants for the serial master control/status block: register offsets,
 field positions, reset values and write masks.
 Assumes a byte-addressed register port where each register is one word.
*/
package smcs_pkg;
   localparam int          ADDR_W      = 8;
   localparam logic [7:0]  OFF_CTRL    = 8'h00;
   localparam logic [7:0]  OFF_FIFO    = 8'h04;
   // Field positions of the control/status word
   localparam int BIT_LONGWORD  = 25;
   localparam int BIT_LSDMA     = 24;
   localparam int BIT_SELPOL0   = 21;
   localparam int BIT_RXFULL    = 20;
   localparam int BIT_RXNEED    = 19;
   localparam int BIT_TXSPACE   = 18;
   localparam int BIT_RXDATA    = 17;
   localparam int BIT_DONE      = 16;
   localparam int BIT_LSPROT    = 13;
   localparam int BIT_READEN    = 12;
   localparam int BIT_AUTOREL   = 11;
   localparam int BIT_RXIEN     = 10;
   localparam int BIT_DONEIEN   = 9;
   localparam int BIT_DMA_REQUEST_ENABLE     = 8;
   localparam int BIT_ACTIVE    = 7;
   localparam int BIT_GPOL      = 6;
   localparam int BIT_CLRTX     = 4;
   localparam int BIT_CLRRX     = 5;
   localparam int BIT_CLOCK_REST_POLARITY      = 3;
   localparam int BIT_CLOCK_PHASE      = 2;
   localparam int BIT_SEL       = 0;
   localparam int LEN_LSB       = 16;
   // Writable bits; clear field and flags are not stored
   localparam logic [31:0] CTRL_WMASK  = 32'h03E0_FFCF;
   localparam logic [7:0]  LOAD_WMASK  = 8'hCF;
   localparam logic [31:0] CTRL_RESET  = 32'h0000_1000;
   localparam logic [1:0]  SEL_RESERVED = 2'h3;
endpackage : smcs_pkg

// File: tb/smcs_fifo_model.sv
/*
 Partner model: transmit and receive FIFOs plus a byte shifter that loops
 every sent byte back into the receive FIFO, one byte per four clocks.
 Assumes the control block's clock, strobes and level conventions.
*/
`timescale 1ns/1ps
module smcs_fifo_model #(
   parameter int DEPTH = 8,
   parameter int LW    = 4
) (
   input  wire logic          clk,
   input  wire logic          txPush,
   input  wire logic          txPushWord,
   input  wire logic [31:0]   txData,
   input  wire logic          rxPop,
   input  wire logic          txClear,
   input  wire logic          rxClear,
   input  wire logic          serialHalt,
   output logic      [LW-1:0] txLevel,
   output logic      [LW-1:0] rxLevel,
   output logic      [31:0]   rxHeadData,
   output logic               shifterIdle,
   output logic               byteDone
);
   byte unsigned txQ[$];
   byte unsigned rxQ[$];
   int           cnt  = 0;
   int           tick = 0;
   initial begin
      txLevel = '0;
      rxLevel = '0;
      rxHeadData = 32'h0;
      shifterIdle = 1'b1;
      byteDone = 1'b0;
   end
   // Queues move on the edge; levels follow at once like a real FIFO
   always @(posedge clk) begin
      tick++;
      if (txClear) txQ.delete();
      if (rxClear) rxQ.delete();
      if (rxPop && rxQ.size() > 0) void'(rxQ.pop_front());
      for (int i = 0; i < (txPush ? (txPushWord ? 4 : 1) : 0); i++)
         if (txQ.size() < DEPTH) txQ.push_back(txData[8*i +: 8]);
      if (txQ.size() == 0) cnt = 0;
      // Full receive side or a halt freezes the shifter mid-byte
      if (txQ.size() > 0 && !serialHalt && rxQ.size() < DEPTH) cnt++;
      byteDone <= (cnt == 4);
      if (cnt == 4) begin
         rxQ.push_back(txQ.pop_front());
         cnt = 0;
      end
      txLevel <= LW'(txQ.size());
      rxLevel <= LW'(rxQ.size());
      // Empty head shows a moving pattern, never a stale byte
      rxHeadData <= rxQ.size() ? {24'h0, rxQ[0]} : 32'hC3C3_0000 ^ tick;
      shifterIdle <= (cnt == 0);
   end
endmodule : smcs_fifo_model

// File: tb/spi_master_control_status_tb.sv
/*
 Self-checking bench for the control/status block with a FIFO partner.
 Assumes small FIFO depth and thresholds set through the parameters.
*/
`timescale 1ns/1ps
module spi_master_control_status_tb;
   import smcs_pkg::*;
   localparam int DEPTH = 8;
   localparam int LW    = 4;
   logic clk, rst_n, busWrite, busRead, dmaFrameEnd, txPush, txPushWord;
   logic rxPop, txClear, rxClear, serialHalt, clockRestHigh, clockPhase;
   logic lowspeedProtocolSelect, lineTurnToSlave, dmaTxReq, dmaRxReq, irq;
   logic shifterIdle, byteDone;
   logic [7:0]    busAddr;
   logic [31:0]   busWdata, busRdata, txData, rxHeadData, ctl, w, d;
   logic [LW-1:0] txLevel, rxLevel;
   logic [2:0]    selectOut;
   logic [15:0]   transferLength;
   logic [31:0]   modes[4] = '{32'h0, 32'h100, 32'h0100_2000, 32'h0300_2000};
   int miscompares = 0;
   int testsRun    = 0;
   byte unsigned expQ[$];
   smcs_ctrl_status #(.FIFO_DEPTH(DEPTH), .LVL_W(LW), .RX_HIGH(6),
      .TX_DREQ(4), .RX_DREQ(4)) i_dut (.*);
   smcs_fifo_model #(.DEPTH(DEPTH), .LW(LW)) i_model (.*);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", testsRun, miscompares);
      if (miscompares == 0 && testsRun > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : give_verdict
   // Bus master; the shadow word tracks what software stored
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      busAddr <= a;
      busWdata <= v;
      busWrite <= 1'b1;
      @(posedge clk);
      busWrite <= 1'b0;
      if (a == OFF_CTRL) ctl = v & CTRL_WMASK;
      if (a == OFF_FIFO && !ctl[7]) ctl[7:0] = v[7:0] & LOAD_WMASK;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      busAddr <= a;
      busRead <= 1'b1;
      @(posedge clk);
      busRead <= 1'b0;
      #1 v = busRdata;
   endtask : rd
   function automatic logic [2:0] expSel();
      logic [2:0] v;
      for (int i = 0; i < 3; i++)
         v[i] = (ctl[6] | ctl[21+i]) ^ !(ctl[7] && ctl[1:0] == i);
      return v;
   endfunction : expSel
   // Status expected from the partner's fill levels; call only when settled
   task automatic chkStat();
      logic [31:0] s;
      int t, r;
      t = txLevel;
      r = rxLevel;
      s = ctl & CTRL_WMASK;
      s[20:16] = {r == DEPTH, ctl[7] && r >= 6, t != DEPTH, r != 0,
                  ctl[7] && t == 0};
      check(irq, (ctl[10] && s[19]) || (ctl[9] && s[16]));
      if (s[20]) check(serialHalt, 1'b1);
      rd(OFF_CTRL, d);
      check(d, s);
   endtask : chkStat
   initial begin
      repeat (50000) @(posedge clk);
      miscompares++;
      give_verdict();
   end
   initial begin
      void'($urandom(62));
      {rst_n, busWrite, busRead, dmaFrameEnd, busAddr, busWdata} = '0;
      ctl = CTRL_RESET;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      chkStat();
      check({selectOut, lineTurnToSlave, dmaTxReq}, 5'h1E);
      // Random inactive settings, DMA kept off
      for (int i = 0; i < 4; i++) begin
         w = $urandom() & ~32'h0100_0180;
         wr(OFF_CTRL, w);
         @(posedge clk);
         #1 check({clockRestHigh, clockPhase, lowspeedProtocolSelect,
                   lineTurnToSlave}, {w[3], w[2], w[13], w[12]});
         check(selectOut, expSel());
         chkStat();
      end
      // Every select code under both global polarities
      for (int i = 0; i < 8; i++) begin
         wr(OFF_CTRL, {8'h0, 3'($urandom()), 13'h0, 1'b1, i[2], 4'h0, i[1:0]});
         @(posedge clk);
         #1 check(selectOut, expSel());
      end
      wr(OFF_CTRL, ctl & ~32'h80);
      @(posedge clk);
      #1 check(selectOut, expSel());
      wr(8'h08, 32'hFFFF_FFFF);
      rd(8'h08, d);
      check(d, 32'h0);
      // Polled transfer: bytes loop back through the partner
      wr(OFF_CTRL, 32'h0000_0680);
      repeat (4) @(posedge clk);
      chkStat();
      for (int i = 0; i < 3; i++) begin
         w = $urandom();
         expQ.push_back(w[7:0]);
         wr(OFF_FIFO, w);
         check({txPush, txPushWord, txData[7:0]}, {2'b10, w[7:0]});
      end
      repeat (40) @(posedge clk);
      chkStat();
      while (expQ.size() > 0) begin
         rd(OFF_FIFO, d);
         check(d, {24'h0, expQ.pop_front()});
      end
      chkStat();
      // Overrun both FIFOs, then drop active, then clear with active
      for (int i = 0; i < 20; i++) wr(OFF_FIFO, $urandom());
      repeat (100) @(posedge clk);
      chkStat();
      // Service the needs-reading event: twelve reads, then poll again
      check(irq, 1'b1);
      for (int i = 0; i < 12; i++) rd(OFF_FIFO, d);
      repeat (100) @(posedge clk);
      chkStat();
      wr(OFF_CTRL, 32'h0000_0600);
      chkStat();
      wr(OFF_CTRL, 32'h0000_00B0);
      check({txClear, rxClear}, 2'b11);
      repeat (4) @(posedge clk);
      chkStat();
      for (int c = 1; c < 4; c++) begin
         wr(OFF_CTRL, 32'(c) << 4);
         check({txClear, rxClear}, {c[0], c[1]});
      end
      // Word or byte pushes and DMA requests per mode
      for (int i = 0; i < 4; i++) begin
         wr(OFF_CTRL, modes[i] | 32'h80);
         wr(OFF_FIFO, 32'h4433_2211);
         check(txPushWord, modes[i][8] | modes[i][25]);
         check(dmaTxReq, modes[i][8] | modes[i][24]);
         repeat (40) @(posedge clk);
         #1 check(dmaRxReq, modes[i][8] | modes[i][24]);
         chkStat();
         wr(OFF_CTRL, 32'h30);
      end
      // DMA frame with auto release, then frame end from the engine
      wr(OFF_CTRL, 32'h0000_0900);
      wr(OFF_FIFO, 32'h0004_0081);
      check(transferLength, 32'h4);
      @(posedge clk);
      #1 check(selectOut, expSel());
      wr(OFF_FIFO, $urandom());
      repeat (40) @(posedge clk);
      #1 check(selectOut, 3'h7);
      dmaFrameEnd <= 1'b1;
      @(posedge clk);
      dmaFrameEnd <= 1'b0;
      ctl[7] = 1'b0;
      repeat (2) @(posedge clk);
      chkStat();
      give_verdict();
   end
endmodule : spi_master_control_status_tb
